// File: rtl/ctrt_defs.vh
`ifndef CTRT_DEFS_VH
`define CTRT_DEFS_VH

// ============================================================
// Register byte offsets
`define CTRT_OFS_AUX_CTRL 8'h00
`define CTRT_OFS_DIV_UPPER 8'h04
`define CTRT_OFS_DIV_LOWER 8'h08
`define CTRT_OFS_CNT_UPPER 8'h0c
`define CTRT_OFS_CNT_LOWER 8'h10
`define CTRT_OFS_START 8'h14
`define CTRT_OFS_STOP 8'h18
`define CTRT_OFS_IRQ_STATUS 8'h1c
`define CTRT_OFS_IRQ_MASK 8'h20
`define CTRT_OFS_CMD_A 8'h24
`define CTRT_OFS_CMD_B 8'h28
`define CTRT_OFS_CSEL_A 8'h2c
`define CTRT_OFS_CSEL_B 8'h30

// ============================================================
// Field positions
`define CTRT_ACR_MODE_BIT 6
`define CTRT_ACR_SRC_HI 5
`define CTRT_ACR_SRC_LO 4
`define CTRT_RDY_BIT 3

// ============================================================
// Codes
`define CTRT_CMD_TO_ON 4'ha
`define CTRT_CMD_TO_OFF 4'hc
`define CTRT_CSEL_CT 4'hd
`define CTRT_SRC_EXT 2'h0
`define CTRT_SRC_EXT16 2'h1
`define CTRT_SRC_SYS16 2'h2
`define CTRT_SRC_SYS 2'h3

// ============================================================
// Reset values and counting constants
`define CTRT_RST_BYTE 8'h00
`define CTRT_RST_COUNT 16'h0000
`define CTRT_RST_RDATA 32'h0000_0000
`define CTRT_COUNT_ONE 16'h0001
`define CTRT_PRE_LAST 4'hf

`endif

// File: rtl/ctrt_sync2.v
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Two-stage synchroniser for one asynchronous level
module ctrt_sync2 (
	input wire clk_sys,
	input wire srst,
	input wire din,
	output reg dout_q
);

reg meta_q;

always @(posedge clk_sys) begin
	if (srst) begin
		meta_q <= 1'b0;
		dout_q <= 1'b0;
	end else begin
		meta_q <= din;
		dout_q <= meta_q;
	end
end

endmodule // ctrt_sync2

`default_nettype wire

// File: rtl/ctrt_tick_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "ctrt_defs.vh"

// ============================================================
// Counter clock selection: one-cycle tick per active edge, or per 16 edges for the /16 sources
module ctrt_tick_gen (
	input wire clk_sys,
	input wire srst,
	input wire ext_sync,
	input wire [1:0] src_sel,
	output reg tick_q
);

reg ext_prev_q;
reg [3:0] pre_q;
reg [3:0] pre_d;
reg base_ev;
reg tick_d;
wire ext_rise;

assign ext_rise = ext_sync & ~ext_prev_q;

always @* begin
	pre_d = pre_q;
	tick_d = 1'b0;
	case (src_sel)
		`CTRT_SRC_EXT: base_ev = ext_rise;
		`CTRT_SRC_EXT16: base_ev = ext_rise;
		`CTRT_SRC_SYS16: base_ev = 1'b1;
		default: base_ev = 1'b1;
	endcase
	if (base_ev) begin
		pre_d = pre_q + 4'h1;
		if (src_sel == `CTRT_SRC_EXT || src_sel == `CTRT_SRC_SYS) begin
			tick_d = 1'b1;
		end else begin
			tick_d = (pre_q == `CTRT_PRE_LAST);
		end
	end
end

always @(posedge clk_sys) begin
	if (srst) begin
		ext_prev_q <= 1'b0;
		pre_q <= 4'h0;
		tick_q <= 1'b0;
	end else begin
		ext_prev_q <= ext_sync;
		pre_q <= pre_d;
		tick_q <= tick_d;
	end
end

endmodule // ctrt_tick_gen

`default_nettype wire

// File: rtl/ctrt_counter_timer.v
// Overview of operation
// - Start read copies both divisor registers into count; start/stop are reads, data ignored.
// - Clock source and counter/timer choice come from aux control bits 6 to 4.
// - Timer mode toggles output every divisor ticks: symmetrical square wave.
// - Timer sets ready on each falling output edge, even after stop; stop clears it.
// - Channel directions clocked from the counter/timer run in 16x mode.
// - Counter mode counts loaded value to zero, then sets ready and drops output.
// - After zero the counter wraps to all ones and runs on silently.
// - Count reads in counter mode return the live count.
// - Each receive load of a channel in timeout mode: stop after one tick, reload, restart on the next tick.
// - Timeout expiry sets ready; with mask bit 3 set it raises the interrupt.
// - A character after expiry restarts the count, clearing ready and interrupt.
// - Command code A turns channel timeout mode on, code C turns it off.
// - Timeout-on also clears ready and holds the counter until the next character.
// - In timeout mode start/stop are ignored; counter mode driven by receive loads.
// - With both channels on, restart is the OR of both receive loads.
// - Six operations: start, stop, read lower and upper count, write lower and upper divisor.
// - Status reads zero when no interrupt condition is active.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "ctrt_defs.vh"

module ctrt_counter_timer (
	input wire clk_sys,
	input wire srst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire ct_ext_clk,
	input wire rx_load_a,
	input wire rx_load_b,
	output reg ct_out,
	output reg ct_irq,
	output reg rx_a_ct16x,
	output reg tx_a_ct16x,
	output reg rx_b_ct16x,
	output reg tx_b_ct16x
);

// ============================================================
// Helpers
function is_ct_sel;
	input [3:0] nib;
	begin
		is_ct_sel = (nib == `CTRT_CSEL_CT);
	end
endfunction

function hit;
	input [7:0] addr;
	input [7:0] ofs;
	begin
		hit = (addr == ofs);
	end
endfunction

// ============================================================
// State
reg [7:0] aux_ctrl_q;
reg [7:0] div_upper_q;
reg [7:0] div_lower_q;
reg [7:0] irq_mask_q;
reg [7:0] csel_a_q;
reg [7:0] csel_b_q;
reg [15:0] count_q;
reg run_q;
reg rdy_q;
reg pend_q;
reg restart_q;
reg to_a_q;
reg to_b_q;
reg [31:0] rd_d;

wire ext_sync;
wire tick;
wire acc_rd;
wire acc_wr;
wire wr_lo;
wire [7:0] wdat;
wire [15:0] divisor;
wire to_active;
wire timer_eff;
wire start_cmd;
wire stop_cmd;
wire cmd_a_wr;
wire cmd_b_wr;
wire to_on_a;
wire to_off_a;
wire to_on_b;
wire to_off_b;
wire to_on_any;
wire rx_ev;
wire cnt_tick;
wire expire;
wire tmr_tick;
wire half_done;
wire fall;

// ============================================================
// Counter clock path
ctrt_sync2 u_sync (
	.clk_sys(clk_sys),
	.srst(srst),
	.din(ct_ext_clk),
	.dout_q(ext_sync)
);

ctrt_tick_gen u_tick (
	.clk_sys(clk_sys),
	.srst(srst),
	.ext_sync(ext_sync),
	.src_sel(aux_ctrl_q[`CTRT_ACR_SRC_HI:`CTRT_ACR_SRC_LO]),
	.tick_q(tick)
);

// ============================================================
// Bus decode: one wait state per access
assign acc_rd = avs_read & avs_waitrequest;
assign acc_wr = avs_write & avs_waitrequest & ~avs_read;
assign wr_lo = acc_wr & avs_byteenable[0];
assign wdat = avs_writedata[7:0];
assign divisor = {div_upper_q, div_lower_q};

assign to_active = to_a_q | to_b_q;
assign timer_eff = aux_ctrl_q[`CTRT_ACR_MODE_BIT] & ~to_active;

// Start and stop are read strobes; ignored while timeout mode runs
assign start_cmd = acc_rd & hit(avs_address, `CTRT_OFS_START) & ~to_active;
assign stop_cmd = acc_rd & hit(avs_address, `CTRT_OFS_STOP) & ~to_active;

assign cmd_a_wr = wr_lo & hit(avs_address, `CTRT_OFS_CMD_A);
assign cmd_b_wr = wr_lo & hit(avs_address, `CTRT_OFS_CMD_B);
assign to_on_a = cmd_a_wr & (wdat[7:4] == `CTRT_CMD_TO_ON);
assign to_off_a = cmd_a_wr & (wdat[7:4] == `CTRT_CMD_TO_OFF);
assign to_on_b = cmd_b_wr & (wdat[7:4] == `CTRT_CMD_TO_ON);
assign to_off_b = cmd_b_wr & (wdat[7:4] == `CTRT_CMD_TO_OFF);
assign to_on_any = to_on_a | to_on_b;

// Receive loads of either enabled channel restart the count
assign rx_ev = (rx_load_a & to_a_q) | (rx_load_b & to_b_q);

// ============================================================
// Count events
assign cnt_tick = tick & run_q & ~timer_eff & ~pend_q & ~restart_q & ~to_on_any
	& ~start_cmd & ~stop_cmd;
assign expire = cnt_tick & (count_q == `CTRT_COUNT_ONE);
assign tmr_tick = tick & timer_eff & ~start_cmd & ~stop_cmd;
assign half_done = tmr_tick & (count_q <= `CTRT_COUNT_ONE);
assign fall = half_done & ct_out;

// ============================================================
// Registers written by software
always @(posedge clk_sys) begin
	if (srst) begin
		aux_ctrl_q <= `CTRT_RST_BYTE;
		div_upper_q <= `CTRT_RST_BYTE;
		div_lower_q <= `CTRT_RST_BYTE;
		irq_mask_q <= `CTRT_RST_BYTE;
		csel_a_q <= `CTRT_RST_BYTE;
		csel_b_q <= `CTRT_RST_BYTE;
	end else if (wr_lo) begin
		case (avs_address)
			`CTRT_OFS_AUX_CTRL: aux_ctrl_q <= wdat;
			`CTRT_OFS_DIV_UPPER: div_upper_q <= wdat;
			`CTRT_OFS_DIV_LOWER: div_lower_q <= wdat;
			`CTRT_OFS_IRQ_MASK: irq_mask_q <= wdat;
			`CTRT_OFS_CSEL_A: csel_a_q <= wdat;
			`CTRT_OFS_CSEL_B: csel_b_q <= wdat;
			default: aux_ctrl_q <= aux_ctrl_q;
		endcase
	end
end

// ============================================================
// Timeout mode enables per channel
always @(posedge clk_sys) begin
	if (srst) begin
		to_a_q <= 1'b0;
		to_b_q <= 1'b0;
	end else begin
		if (to_on_a) begin
			to_a_q <= 1'b1;
		end else if (to_off_a) begin
			to_a_q <= 1'b0;
		end
		if (to_on_b) begin
			to_b_q <= 1'b1;
		end else if (to_off_b) begin
			to_b_q <= 1'b0;
		end
	end
end

// ============================================================
// Counting register
always @(posedge clk_sys) begin
	if (srst) begin
		count_q <= `CTRT_RST_COUNT;
		run_q <= 1'b0;
		restart_q <= 1'b0;
	end else if (to_on_any) begin
		run_q <= 1'b0;
		restart_q <= 1'b0;
	end else if (to_active) begin
		if (tick) begin
			if (pend_q) begin
				count_q <= divisor;
				run_q <= 1'b0;
				restart_q <= 1'b1;
			end else if (restart_q) begin
				run_q <= 1'b1;
				restart_q <= 1'b0;
			end else if (run_q) begin
				count_q <= count_q - `CTRT_COUNT_ONE;
			end
		end
	end else if (start_cmd) begin
		count_q <= divisor;
		run_q <= 1'b1;
		restart_q <= 1'b0;
	end else if (stop_cmd) begin
		run_q <= timer_eff;
		restart_q <= 1'b0;
	end else begin
		restart_q <= 1'b0;
		if (tmr_tick) begin
			if (half_done) begin
				count_q <= divisor;
			end else begin
				count_q <= count_q - `CTRT_COUNT_ONE;
			end
		end else if (cnt_tick) begin
			count_q <= count_q - `CTRT_COUNT_ONE;
		end
	end
end

// ============================================================
// Pending receive load: an event beside its consumption is kept
always @(posedge clk_sys) begin
	if (srst) begin
		pend_q <= 1'b0;
	end else if (!to_active) begin
		pend_q <= 1'b0;
	end else if (rx_ev) begin
		pend_q <= 1'b1;
	end else if (tick || to_on_any) begin
		pend_q <= 1'b0;
	end
end

// ============================================================
// Ready flag and counter output
always @(posedge clk_sys) begin
	if (srst) begin
		rdy_q <= 1'b0;
	end else if (expire || fall) begin
		rdy_q <= 1'b1;
	end else if (stop_cmd || to_on_any) begin
		rdy_q <= 1'b0;
	end else if (to_active && tick && pend_q) begin
		rdy_q <= 1'b0;
	end
end

always @(posedge clk_sys) begin
	if (srst) begin
		ct_out <= 1'b1;
	end else if (start_cmd) begin
		ct_out <= 1'b1;
	end else if (stop_cmd && !timer_eff) begin
		ct_out <= 1'b1;
	end else if (half_done) begin
		ct_out <= ~ct_out;
	end else if (expire) begin
		ct_out <= 1'b0;
	end else if (to_active && tick && pend_q) begin
		ct_out <= 1'b1;
	end
end

// Interrupt follows the ready flag through the mask
always @(posedge clk_sys) begin
	if (srst) begin
		ct_irq <= 1'b0;
	end else begin
		ct_irq <= rdy_q & irq_mask_q[`CTRT_RDY_BIT];
	end
end

// ============================================================
// Counter/timer clocked channel directions
always @(posedge clk_sys) begin
	if (srst) begin
		rx_a_ct16x <= 1'b0;
		tx_a_ct16x <= 1'b0;
		rx_b_ct16x <= 1'b0;
		tx_b_ct16x <= 1'b0;
	end else begin
		rx_a_ct16x <= is_ct_sel(csel_a_q[7:4]);
		tx_a_ct16x <= is_ct_sel(csel_a_q[3:0]);
		rx_b_ct16x <= is_ct_sel(csel_b_q[7:4]);
		tx_b_ct16x <= is_ct_sel(csel_b_q[3:0]);
	end
end

// ============================================================
// Read data
always @* begin
	rd_d = `CTRT_RST_RDATA;
	case (avs_address)
		`CTRT_OFS_AUX_CTRL: rd_d[7:0] = aux_ctrl_q;
		`CTRT_OFS_DIV_UPPER: rd_d[7:0] = div_upper_q;
		`CTRT_OFS_DIV_LOWER: rd_d[7:0] = div_lower_q;
		`CTRT_OFS_CNT_UPPER: rd_d[7:0] = count_q[15:8];
		`CTRT_OFS_CNT_LOWER: rd_d[7:0] = count_q[7:0];
		`CTRT_OFS_IRQ_STATUS: rd_d[`CTRT_RDY_BIT] = rdy_q;
		`CTRT_OFS_IRQ_MASK: rd_d[7:0] = irq_mask_q;
		`CTRT_OFS_CSEL_A: rd_d[7:0] = csel_a_q;
		`CTRT_OFS_CSEL_B: rd_d[7:0] = csel_b_q;
		`CTRT_OFS_CMD_A: rd_d[7:0] = {7'h00, to_a_q};
		`CTRT_OFS_CMD_B: rd_d[7:0] = {7'h00, to_b_q};
		default: rd_d = `CTRT_RST_RDATA;
	endcase
end

always @(posedge clk_sys) begin
	if (srst) begin
		avs_readdata <= `CTRT_RST_RDATA;
		avs_waitrequest <= 1'b1;
	end else begin
		avs_waitrequest <= ~(acc_rd | acc_wr);
		if (acc_rd) begin
			avs_readdata <= rd_d;
		end
	end
end

endmodule // ctrt_counter_timer

`default_nettype wire

// File: rtl/ctrt_placeholder_unused.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: testbench/ctrt_counter_timer_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctrt_defs.vh"
// ============================================================
// Port relations of the counter/timer
module ctrt_counter_timer_asserts (
	input wire clk_sys,
	input wire srst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire ct_out,
	input wire ct_irq,
	input wire rx_a_ct16x
);
	logic mask_q;
	wire rd_ans = !avs_waitrequest && avs_read;
	wire wr_ans = !avs_waitrequest && avs_write;
	// Mirror of the counter ready mask bit
	always @(posedge clk_sys) begin
		if (srst)
			mask_q <= 1'h0;
		else if (wr_ans && avs_address == `CTRT_OFS_IRQ_MASK)
			mask_q <= avs_writedata[3];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	AST_WAIT_ONE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("wait low too long");
	AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer");
	AST_STAT_ZERO: assert property (rd_ans && avs_address == `CTRT_OFS_IRQ_STATUS
		|-> avs_readdata[31:4] == 28'h000_0000 && avs_readdata[2:0] == 3'h0)
		else $error("status bits");
	AST_RD_UPPER: assert property (rd_ans |-> avs_readdata[31:8] == 24'h00_0000)
		else $error("upper read bits");
	AST_UNMAP: assert property (rd_ans && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read");
	AST_FALL_IRQ: assert property ($fell(ct_out) && mask_q |-> ##[1:2] ct_irq)
		else $error("fall without irq");
	// Mirror lags the mask by one cycle, as the interrupt lags the ready flag
	AST_MASK_OFF: assert property (!mask_q |-> !ct_irq)
		else $error("masked irq");
	AST_RX16: assert property (wr_ans && avs_address == `CTRT_OFS_CSEL_A
		&& avs_writedata[7:4] == `CTRT_CSEL_CT |-> ##[1:2] rx_a_ct16x)
		else $error("16x flag");
	cover property ($fell(ct_out));
	cover property ($rose(ct_irq));
	cover property (rd_ans && avs_address == `CTRT_OFS_CNT_LOWER);
endmodule // ctrt_counter_timer_asserts
bind ctrt_counter_timer ctrt_counter_timer_asserts i_asserts (.clk_sys, .srst, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .ct_out, .ct_irq,
	.rx_a_ct16x);
`default_nettype wire

// File: testbench/ctrt_host.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Host bus master
module ctrt_host (
	input wire clk_sys,
	input wire avs_waitrequest,
	input wire [31:0] avs_readdata,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable
);
	initial begin
		avs_address = 8'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h1;
	end
	// Held until waitrequest is seen low; count reads only trusted outside timer mode
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
		q = avs_readdata[7:0];
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		avs_writedata <= ~avs_writedata;
		@(posedge clk_sys);
	endtask
endmodule // ctrt_host
`default_nettype wire

// File: testbench/ctrt_counter_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctrt_defs.vh"
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))
// ============================================================
// Register sequences with expected values
module ctrt_counter_timer_test;
	logic clk_sys;
	logic srst;
	logic rx_load_a;
	logic rx_load_b;
	logic ct_ext_clk;
	int fail_count;
	int n_tests;
	int n;
	logic [7:0] q1;
	logic [7:0] q2;
	wire [7:0] avs_address;
	wire avs_read;
	wire avs_write;
	wire [31:0] avs_writedata;
	wire [3:0] avs_byteenable;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire ct_out;
	wire ct_irq;
	wire [3:0] c16;
	ctrt_host i_host (.clk_sys, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable);
	ctrt_counter_timer i_dut (.clk_sys, .srst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ct_ext_clk,
		.rx_load_a, .rx_load_b, .ct_out, .ct_irq, .rx_a_ct16x(c16[3]), .tx_a_ct16x(c16[2]),
		.rx_b_ct16x(c16[1]), .tx_b_ct16x(c16[0]));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_host.xfer(1'h1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		i_host.xfer(1'h0, a, 8'h00, q);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		rd(a, q);
		`CHK(nm, e, q);
	endtask
	task automatic rx(input logic b);
		if (b) rx_load_b <= 1'h1;
		else rx_load_a <= 1'h1;
		@(posedge clk_sys);
		rx_load_a <= 1'h0;
		rx_load_b <= 1'h0;
	endtask
	task automatic until_out(input logic v);
		n = 0;
		while (ct_out !== v && n < 1000) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	task automatic ext_run(input int k, input logic [7:0] e, input string nm);
		rd(`CTRT_OFS_CNT_LOWER, q1);
		repeat (k) begin
			ct_ext_clk <= 1'h1;
			cyc(2);
			ct_ext_clk <= 1'h0;
			cyc(2);
		end
		cyc(6);
		rd(`CTRT_OFS_CNT_LOWER, q2);
		`CHK(nm, e, 8'(q1 - q2));
	endtask
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (6000) @(posedge clk_sys);
		fail_count++;
		print_verdict();
	end
	initial begin
		srst = 1'h1;
		rx_load_a = 1'h0;
		rx_load_b = 1'h0;
		ct_ext_clk = 1'h0;
		fail_count = 0;
		n_tests = 0;
		cyc(2);
		srst <= 1'h0;
		@(posedge clk_sys);
		`CHK("out reset", 1'h1, ct_out);
		`CHK("irq reset", 1'h0, ct_irq);
		rc("status reset", `CTRT_OFS_IRQ_STATUS, 8'h00);
		// ============================================================
		// Counter mode, tick every cycle
		wr(`CTRT_OFS_AUX_CTRL, 8'h30);
		wr(`CTRT_OFS_DIV_UPPER, 8'h00);
		wr(`CTRT_OFS_DIV_LOWER, 8'h05);
		rd(`CTRT_OFS_START, q1);
		until_out(1'h0);
		`CHK("count fall", 1'h0, ct_out);
		rc("ready", `CTRT_OFS_IRQ_STATUS, 8'h08);
		rc("wrap", `CTRT_OFS_CNT_UPPER, 8'hff);
		cyc(20);
		`CHK("quiet wrap", 1'h0, ct_out);
		rd(`CTRT_OFS_CNT_LOWER, q1);
		rd(`CTRT_OFS_CNT_LOWER, q2);
		`CHK("live step", 8'h03, 8'(q1 - q2));
		wr(`CTRT_OFS_IRQ_MASK, 8'h08);
		cyc(2);
		`CHK("irq", 1'h1, ct_irq);
		rd(`CTRT_OFS_STOP, q1);
		cyc(2);
		`CHK("irq stop", 1'h0, ct_irq);
		rc("ready stop", `CTRT_OFS_IRQ_STATUS, 8'h00);
		rd(`CTRT_OFS_CNT_LOWER, q1);
		wr(`CTRT_OFS_DIV_LOWER, 8'h40);
		rc("count held", `CTRT_OFS_CNT_LOWER, q1);
		// ============================================================
		// Timer mode
		wr(`CTRT_OFS_AUX_CTRL, 8'h70);
		wr(`CTRT_OFS_DIV_LOWER, 8'h03);
		rd(`CTRT_OFS_START, q1);
		until_out(1'h0);
		until_out(1'h1);
		`CHK("low half", 16'h0003, n);
		until_out(1'h0);
		`CHK("high half", 16'h0003, n);
		rd(`CTRT_OFS_STOP, q1);
		until_out(1'h1);
		until_out(1'h0);
		rc("ready runs", `CTRT_OFS_IRQ_STATUS, 8'h08);
		// ============================================================
		// Receive timeout mode
		wr(`CTRT_OFS_AUX_CTRL, 8'h30);
		wr(`CTRT_OFS_DIV_LOWER, 8'h10);
		wr(`CTRT_OFS_CMD_A, 8'ha0);
		rc("to on", `CTRT_OFS_CMD_A, 8'h01);
		rc("on clears", `CTRT_OFS_IRQ_STATUS, 8'h00);
		cyc(40);
		rc("held", `CTRT_OFS_IRQ_STATUS, 8'h00);
		rx(1'h0);
		cyc(8);
		rc("running", `CTRT_OFS_IRQ_STATUS, 8'h00);
		cyc(12);
		rc("expired", `CTRT_OFS_IRQ_STATUS, 8'h08);
		rd(`CTRT_OFS_STOP, q1);
		rc("stop ignored", `CTRT_OFS_IRQ_STATUS, 8'h08);
		`CHK("to irq", 1'h1, ct_irq);
		rx(1'h0);
		cyc(3);
		`CHK("irq gone", 1'h0, ct_irq);
		rc("status gone", `CTRT_OFS_IRQ_STATUS, 8'h00);
		wr(`CTRT_OFS_CMD_B, 8'ha0);
		cyc(30);
		rx(1'h0);
		cyc(10);
		rx(1'h1);
		cyc(9);
		rc("b busy", `CTRT_OFS_IRQ_STATUS, 8'h00);
		cyc(20);
		rc("both idle", `CTRT_OFS_IRQ_STATUS, 8'h08);
		wr(`CTRT_OFS_CMD_A, 8'hc0);
		wr(`CTRT_OFS_CMD_B, 8'hc0);
		rc("to off", `CTRT_OFS_CMD_A, 8'h00);
		wr(`CTRT_OFS_CSEL_A, 8'hdd);
		wr(`CTRT_OFS_CSEL_B, 8'hd0);
		cyc(2);
		`CHK("16x", 4'he, c16);
		rc("unmapped", 8'hfc, 8'h00);
		rc("misaligned", 8'h05, 8'h00);
		// ============================================================
		// Clock sources: system/16, external edges, external/16
		wr(`CTRT_OFS_AUX_CTRL, 8'h20);
		rd(`CTRT_OFS_START, q1);
		rd(`CTRT_OFS_CNT_LOWER, q1);
		cyc(29);
		rd(`CTRT_OFS_CNT_LOWER, q2);
		`CHK("sys16 step", 8'h02, 8'(q1 - q2));
		wr(`CTRT_OFS_AUX_CTRL, 8'h00);
		ext_run(3, 8'h03, "ext step");
		wr(`CTRT_OFS_AUX_CTRL, 8'h10);
		ext_run(16, 8'h01, "ext16 step");
		print_verdict();
	end
endmodule // ctrt_counter_timer_test
`default_nettype wire
